// ---- hw/hssr_dev.sv ----
// What this block does
// - word length is seven or eight only
// - word length at 84, default eight
// - parity 0 none, 1 even, 2 odd
// - parity at 85, default none
// - one or two stop bits
// - stop bits at 86, default one
// - host should prefer eight data bits
// - host should prefer one stop bit
// - radio profile at 92, default zero
// - write frame 0x09, answer 0x49 status
// - read frame 0x0A, answer 0x4A data
// - ready shown by flow control low
// - ready within one second of power-on
// - clock then channel calibration before ready
// - host holds reset pin low 10 ms
// - flow control high after pin release
// - host waits 100 us after ready
// - serious error restarts, volatile state cleared
// - sleep when nothing is pending
// - wake keeps calibration, ready in microseconds
// - symbol rate defaults to 9600
module hssr_dev
	import hssr_pkg::*;
#(
	parameter int CAL_CYC_P = CAL_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link to host
	hssr_link_if.dev link,
	// internal fault pulse
	input wire logic internal_fault,
	// active settings
	output logic [7:0] cfg_word_len,
	output logic [7:0] cfg_parity,
	output logic [7:0] cfg_stop_bits,
	output logic [7:0] cfg_profile,
	output logic [31:0] cfg_baud,
	// power state
	output logic low_power
);

	// whole device state
	typedef struct packed {
		hssr_dst_type st; // sequencing state
		hssr_pst_type ps; // parser state
		logic [19:0] tmr; // delay counter
		logic [7:0] cmd; // received command
		logic [7:0] len; // received length
		logic [7:0] cnt; // body bytes taken
		logic [7:0] cs; // running checksum in
		logic [5:0][7:0] body; // frame body
		logic [3:0][7:0] cfg; // word, parity, stop, profile
		logic [31:0] baud; // symbol rate
		logic [9:0][7:0] rbuf; // reply bytes
		logic [3:0] rlen; // reply checksum index
		logic [3:0] ridx; // reply byte index
		logic [7:0] rcs; // running checksum out
		logic rts_n; // flow control
		logic tx_v; // reply strobe
		logic [7:0] tx_d; // reply byte
		logic lp; // low power flag
	} hssr_dev_state_type;

	hssr_dev_state_type r; // registered state
	hssr_dev_state_type n; // next state

	// map a setting position to {hit, index}
	function automatic logic [2:0] pos_map(input logic [7:0] p);
		case (p)
			POS_WORD: return 3'h4;
			POS_PAR: return 3'h5;
			POS_STOP: return 3'h6;
			POS_PROF: return 3'h7;
			default: return 3'h0;
		endcase
	endfunction

	// check a value against the legal set of its setting
	function automatic logic val_ok(input logic [1:0] i, input logic [7:0] v);
		case (i)
			2'h0: return (v == WORD_7) || (v == DEF_WORD);
			2'h1: return v <= PAR_ODD;
			2'h2: return (v == DEF_STOP) || (v == STOP_2);
			default: return v == DEF_PROF;
		endcase
	endfunction

	// next-state logic
	always_comb begin
		logic [7:0] p;
		logic [7:0] m;
		logic [2:0] h;
		logic ok;
		p = r.body[0];
		m = r.body[1];
		h = 3'h0;
		ok = 1'b1;
		n = r;
		n.tx_v = 1'b0;

		// sequencing
		case (r.st)
			// reset pin released: begin start-up
			D_HOLD: begin
				n.st = D_CLKCAL;
				n.tmr = '0;
			end
			// processor clock calibration
			D_CLKCAL: begin
				if (r.tmr == 20'(CAL_CYC_P - 1)) begin
					n.st = D_CHCAL;
					n.tmr = '0;
				end else begin
					n.tmr = r.tmr + 20'h1;
				end
			end
			// channel precalibration and noise survey
			D_CHCAL: begin
				if (r.tmr == 20'(CHAN_CAL_CYC - 1)) begin
					n.st = D_READY;
					n.tmr = '0;
				end else begin
					n.tmr = r.tmr + 20'h1;
				end
			end
			// awake and idle: count toward sleep
			D_READY: begin
				if (r.ps == P_START && !link.h2d_valid) begin
					if (r.tmr == 20'(IDLE_CYC - 1)) begin
						n.st = D_SLEEP;
						n.tmr = '0;
					end else begin
						n.tmr = r.tmr + 20'h1;
					end
				end else begin
					n.tmr = '0;
				end
			end
			// asleep: a host byte wakes us, calibration kept
			D_SLEEP: begin
				if (link.h2d_valid) begin
					n.st = D_WAKE;
					n.tmr = '0;
				end
			end
			// short wake-up latency
			D_WAKE: begin
				if (r.tmr == 20'(WAKE_CYC - 1)) begin
					n.st = D_READY;
					n.tmr = '0;
				end else begin
					n.tmr = r.tmr + 20'h1;
				end
			end
			// send reply bytes, checksum last
			D_REPLY: begin
				if (r.ridx <= r.rlen) begin
					n.tx_v = 1'b1;
					n.tx_d = (r.ridx == r.rlen) ? r.rcs : r.rbuf[r.ridx];
					n.rcs = r.rcs ^ n.tx_d;
					n.ridx = r.ridx + 4'h1;
				end else begin
					n.st = D_READY;
					n.tmr = '0;
				end
			end
			default: n.st = D_HOLD;
		endcase

		// frame parser, runs while awake or asleep
		if ((r.st inside {D_READY, D_SLEEP, D_WAKE}) && link.h2d_valid) begin
			n.cs = r.cs ^ link.h2d_data;
			case (r.ps)
				// hunt for start byte
				P_START: begin
					if (link.h2d_data == FRM_START) begin
						n.ps = P_CMD;
						n.cs = link.h2d_data;
					end
				end
				// command byte
				P_CMD: begin
					n.cmd = link.h2d_data;
					n.ps = P_LEN;
				end
				// length byte; oversize frames dropped
				P_LEN: begin
					n.len = link.h2d_data;
					n.cnt = '0;
					if (link.h2d_data == 8'h00) begin
						n.ps = P_CS;
					end else if (link.h2d_data > BODY_MAX) begin
						n.ps = P_START;
					end else begin
						n.ps = P_BODY;
					end
				end
				// body bytes
				P_BODY: begin
					n.body[r.cnt[2:0]] = link.h2d_data;
					n.cnt = r.cnt + 8'h01;
					if (n.cnt == r.len) begin
						n.ps = P_CS;
					end
				end
				// checksum: execute only on a match
				P_CS: begin
					n.ps = P_START;
					if (link.h2d_data == r.cs) begin
						if (r.cmd == CMD_SET && r.len >= 8'h03 && m + 8'h02 == r.len) begin
							// all bytes must hit a legal setting
							for (int i = 0; i < 4; i++) begin
								if (8'(i) < m) begin
									h = pos_map(p + 8'(i));
									if (!h[2] || !val_ok(h[1:0], r.body[i + 2])) begin
										ok = 1'b0;
									end
								end
							end
							// store on success only
							for (int i = 0; i < 4; i++) begin
								h = pos_map(p + 8'(i));
								if (ok && 8'(i) < m) begin
									n.cfg[h[1:0]] = r.body[i + 2];
								end
							end
							// status answer
							n.rbuf[0] = FRM_START;
							n.rbuf[1] = RSP_SET;
							n.rbuf[2] = 8'h01;
							n.rbuf[3] = ok ? STAT_OK : STAT_ERR;
							n.rlen = 4'h4;
							n.st = D_REPLY;
							n.ridx = '0;
							n.rcs = '0;
						end else if (r.cmd == CMD_GET && r.len == 8'h02 && m != 8'h00
							&& m <= RD_MAX) begin
							// data answer, unmapped bytes read zero
							n.rbuf[0] = FRM_START;
							n.rbuf[1] = RSP_GET;
							n.rbuf[2] = m + 8'h02;
							n.rbuf[3] = p;
							n.rbuf[4] = m;
							for (int i = 0; i < 4; i++) begin
								h = pos_map(p + 8'(i));
								n.rbuf[i + 5] = h[2] ? r.cfg[h[1:0]] : 8'h00;
							end
							n.rlen = 4'(m + 8'h05);
							n.st = D_REPLY;
							n.ridx = '0;
							n.rcs = '0;
						end
					end
				end
				default: n.ps = P_START;
			endcase
		end

		// serious error: restart, drop volatile state, keep settings
		if (internal_fault) begin
			n.st = D_CLKCAL;
			n.tmr = '0;
			n.ps = P_START;
			n.tx_v = 1'b0;
		end

		// reset pin low holds the device
		if (!link.reset_pin_n) begin
			n.st = D_HOLD;
			n.tmr = '0;
			n.ps = P_START;
			n.tx_v = 1'b0;
		end

		// flow control: high until start-up done, low when ready
		n.rts_n = !(n.st inside {D_READY, D_SLEEP});
		n.lp = (n.st == D_SLEEP);
	end

	// state register; settings take defaults at power-on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.cfg <= {DEF_PROF, DEF_STOP, DEF_PAR, DEF_WORD};
			r.baud <= DEF_BAUD;
			r.rts_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state register
	assign link.rts_n = r.rts_n;
	assign link.d2h_valid = r.tx_v;
	assign link.d2h_data = r.tx_d;
	assign cfg_word_len = r.cfg[0];
	assign cfg_parity = r.cfg[1];
	assign cfg_stop_bits = r.cfg[2];
	assign cfg_profile = r.cfg[3];
	assign cfg_baud = r.baud;
	assign low_power = r.lp;

endmodule

// ---- hw/hssr_pkg.sv ----
package hssr_pkg;
	// command frame bytes
	localparam logic [7:0] FRM_START = 8'h02;
	localparam logic [7:0] CMD_SET = 8'h09;
	localparam logic [7:0] CMD_GET = 8'h0A;
	localparam logic [7:0] RSP_SET = 8'h49;
	localparam logic [7:0] RSP_GET = 8'h4A;
	localparam logic [7:0] STAT_OK = 8'h00;
	localparam logic [7:0] STAT_ERR = 8'h01;
	// setting positions
	localparam logic [7:0] POS_WORD = 8'h54;
	localparam logic [7:0] POS_PAR = 8'h55;
	localparam logic [7:0] POS_STOP = 8'h56;
	localparam logic [7:0] POS_PROF = 8'h5C;
	// setting defaults
	localparam logic [7:0] DEF_WORD = 8'h08;
	localparam logic [7:0] DEF_PAR = 8'h00;
	localparam logic [7:0] DEF_STOP = 8'h01;
	localparam logic [7:0] DEF_PROF = 8'h00;
	localparam logic [31:0] DEF_BAUD = 32'h0000_2580;
	// other legal setting values
	localparam logic [7:0] WORD_7 = 8'h07;
	localparam logic [7:0] PAR_ODD = 8'h02;
	localparam logic [7:0] STOP_2 = 8'h02;
	// frame limits
	localparam logic [7:0] BODY_MAX = 8'h06;
	localparam logic [7:0] RD_MAX = 8'h04;
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int CAL_MIN_MS = 2;
	localparam int CAL_CYC = CAL_MIN_MS * (CLK_HZ / 1000);
	localparam int CHAN_CAL_US = 50;
	localparam int CHAN_CAL_CYC = CHAN_CAL_US * (CLK_HZ / 1000000);
	localparam int WAKE_US = 3;
	localparam int WAKE_CYC = WAKE_US * (CLK_HZ / 1000000);
	localparam int IDLE_CYC = 16;
	localparam int HOST_WAIT_US = 100;
	localparam int HOST_WAIT_CYC = HOST_WAIT_US * (CLK_HZ / 1000000);
	localparam int RST_HOLD_MS = 10;
	localparam int RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
	localparam logic [1:0] TX_GAP = 2'h3;
	// host register map
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_RST = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CMD_RD_BIT = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// device sequencing states
	typedef enum logic [2:0] {D_HOLD, D_CLKCAL, D_CHCAL, D_READY, D_SLEEP, D_WAKE,
		D_REPLY} hssr_dst_type;
	// frame parser states
	typedef enum logic [2:0] {P_START, P_CMD, P_LEN, P_BODY, P_CS} hssr_pst_type;
	// host controller states
	typedef enum logic [1:0] {H_IDLE, H_RESET, H_SEND, H_WAIT} hssr_hst_type;
endpackage

// ---- hw/hssr_link_if.sv ----
// serial command link between host and radio module
interface hssr_link_if;
	logic reset_pin_n; // restart pin, active low
	logic rts_n; // flow control, low = ready
	logic h2d_valid; // host byte strobe
	logic [7:0] h2d_data; // host byte
	logic d2h_valid; // device byte strobe
	logic [7:0] d2h_data; // device byte
	modport dev (input reset_pin_n, h2d_valid, h2d_data, output rts_n, d2h_valid, d2h_data);
	modport host (output reset_pin_n, h2d_valid, h2d_data, input rts_n, d2h_valid, d2h_data);
endinterface

// ---- hw/hssr_host.sv ----
module hssr_host
	import hssr_pkg::*;
#(
	parameter int RST_HOLD_P = RST_HOLD_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link to device
	hssr_link_if.host link,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	// whole host state
	typedef struct packed {
		hssr_hst_type st; // controller state
		logic [19:0] tmr; // reset hold counter
		logic [6:0][7:0] txb; // outgoing frame
		logic [2:0] tlen; // last tx index
		logic [2:0] tidx; // tx index
		logic [1:0] gap; // spacing after a byte
		logic [2:0] rxn; // last rx index
		logic [2:0] rxi; // rx index
		logic [7:0] rcs; // running rx checksum
		logic [7:0] rcmd; // reply command
		logic [7:0] dstat; // reply byte three
		logic [7:0] rval; // read value
		logic busy, ok, err, ready; // status flags
		logic [11:0] rdy; // ready wait counter
		logic pin_n, h2d_v; // link drives
		logic [7:0] h2d_d; // link byte
		logic aw_got, w_got; // write halves held
		logic [7:0] aw_a; // write address
		logic [31:0] w_d; // write data
		logic awready, wready, bvalid, arready, rvalid; // bus handshakes
		logic [1:0] bresp, rresp; // bus answers
		logic [31:0] rdata; // read data
	} hssr_host_state_type;

	hssr_host_state_type r; // registered state
	hssr_host_state_type n; // next state

	// xor of frame bytes before index last
	function automatic logic [7:0] frame_cs(input logic [6:0][7:0] b, input logic [2:0] last);
		logic [7:0] x;
		x = 8'h00;
		for (int i = 0; i < 7; i++) begin
			if (3'(i) < last) begin
				x = x ^ b[i];
			end
		end
		return x;
	endfunction

	// next-state logic
	always_comb begin
		logic [6:0][7:0] t;
		logic chk;
		t = '0;
		chk = 1'b0;
		n = r;
		n.h2d_v = 1'b0;

		// bus: take address and data in either order
		if (awvalid && r.awready) begin
			n.aw_got = 1'b1;
			n.aw_a = awaddr;
		end
		if (wvalid && r.wready) begin
			n.w_got = 1'b1;
			n.w_d = wdata;
		end
		if (bready && r.bvalid) begin
			n.bvalid = 1'b0;
		end

		// controller
		case (r.st)
			// hold reset pin low, then release
			H_RESET: begin
				if (r.tmr == 20'(RST_HOLD_P - 1)) begin
					n.st = H_IDLE;
					n.pin_n = 1'b1;
					n.busy = 1'b0;
				end else begin
					n.tmr = r.tmr + 20'h1;
				end
			end
			// send one byte when device shows ready
			H_SEND: begin
				if (r.gap != 2'h0) begin
					n.gap = r.gap - 2'h1;
				end else if (!link.rts_n) begin
					n.h2d_v = 1'b1;
					n.h2d_d = r.txb[r.tidx];
					n.gap = TX_GAP;
					if (r.tidx == r.tlen) begin
						n.st = H_WAIT;
						n.rxi = '0;
						n.rcs = '0;
					end else begin
						n.tidx = r.tidx + 3'h1;
					end
				end
			end
			// collect and check the reply
			H_WAIT: begin
				if (link.d2h_valid) begin
					n.rcs = r.rcs ^ link.d2h_data;
					if (r.rxi == 3'h1) n.rcmd = link.d2h_data;
					if (r.rxi == 3'h3) n.dstat = link.d2h_data;
					if (r.rxi == 3'h5) n.rval = link.d2h_data;
					if (r.rxi == r.rxn) begin
						chk = (link.d2h_data == r.rcs) && ((r.rxn == 3'h6) ?
							(r.rcmd == RSP_GET) : (r.rcmd == RSP_SET && r.dstat == STAT_OK));
						n.ok = chk;
						n.err = !chk;
						n.busy = 1'b0;
						n.st = H_IDLE;
					end else begin
						n.rxi = r.rxi + 3'h1;
					end
				end
			end
			default: n.st = H_IDLE;
		endcase

		// bus: execute a complete write
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			if (r.aw_a == REG_CMD && r.st == H_IDLE && r.ready) begin
				t[0] = FRM_START;
				t[3] = r.w_d[7:0];
				t[4] = 8'h01;
				if (r.w_d[CMD_RD_BIT]) begin
					t[1] = CMD_GET;
					t[2] = 8'h02;
					t[5] = frame_cs(t, 3'h5);
					n.tlen = 3'h5;
					n.rxn = 3'h6;
				end else begin
					t[1] = CMD_SET;
					t[2] = 8'h03;
					t[5] = r.w_d[15:8];
					t[6] = frame_cs(t, 3'h6);
					n.tlen = 3'h6;
					n.rxn = 3'h4;
				end
				n.txb = t;
				n.st = H_SEND;
				n.tidx = '0;
				n.gap = '0;
				n.busy = 1'b1;
				n.ok = 1'b0;
				n.err = 1'b0;
			end else if (r.aw_a == REG_RST) begin
				n.st = H_RESET;
				n.tmr = '0;
				n.pin_n = 1'b0;
				n.busy = 1'b1;
			end else begin
				n.bresp = RESP_SLVERR;
			end
		end

		// bus: reads answer one cycle after the address
		if (rready && r.rvalid) begin
			n.rvalid = 1'b0;
		end
		if (arvalid && r.arready) begin
			n.rvalid = 1'b1;
			n.rresp = (araddr == REG_STAT) ? RESP_OKAY : RESP_SLVERR;
			n.rdata = (araddr == REG_STAT) ? {8'h00, r.dstat, r.rval, 3'h0, !r.pin_n,
				r.err, r.ok, r.ready, r.busy} : 32'h0000_0000;
		end

		// readiness: flow control low for the settle time
		if (!n.pin_n || r.pin_n != n.pin_n) begin
			n.ready = 1'b0;
			n.rdy = '0;
		end else if (link.rts_n && !r.ready) begin
			n.rdy = '0;
		end else if (!r.ready) begin
			n.rdy = r.rdy + 12'h001;
			n.ready = (r.rdy == 12'(HOST_WAIT_CYC - 1));
		end

		// handshake readies
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		n.arready = !n.rvalid;
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.pin_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state register
	assign link.reset_pin_n = r.pin_n;
	assign link.h2d_valid = r.h2d_v;
	assign link.h2d_data = r.h2d_d;
	assign awready = r.awready;
	assign wready = r.wready;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign arready = r.arready;
	assign rvalid = r.rvalid;
	assign rresp = r.rresp;
	assign rdata = r.rdata;

endmodule

// ---- verif/hssr_assertions.sv ----
module hssr_checker
	import hssr_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link signals
	input wire logic reset_pin_n,
	input wire logic rts_n,
	input wire logic h2d_valid,
	input wire logic [7:0] h2d_data,
	input wire logic d2h_valid,
	input wire logic [7:0] d2h_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// running xor of one reply, back to zero once the checksum has passed
	logic [7:0] sum_r;
	// clears between replies so each frame is judged alone
	always_ff @(posedge aclk) begin
		if (!aresetn || !d2h_valid) begin
			sum_r <= 8'h00;
		end else begin
			sum_r <= sum_r ^ d2h_data;
		end
	end
	// first byte of a reply
	sequence reply_head_s;
		$rose(d2h_valid) && d2h_data == FRM_START;
	endsequence
	// length, status and checksum of a write answer
	sequence set_tail_s;
		d2h_valid && d2h_data == 8'h01 ##1 d2h_valid && d2h_data <= STAT_ERR
			##1 d2h_valid ##1 !d2h_valid;
	endsequence
	pin_hold_a:
		assert property ($fell(reset_pin_n) |-> !reset_pin_n [*8])
		else $error("reset pin released too early");
	pin_rts_a:
		assert property (!reset_pin_n |=> rts_n)
		else $error("flow control low while reset pin held");
	startup_a:
		assert property ($rose(reset_pin_n) |-> rts_n [*8])
		else $error("ready too soon after pin release");
	reply_start_a:
		assert property ($rose(d2h_valid) |-> d2h_data == FRM_START)
		else $error("reply does not open with start byte");
	reply_cmd_a:
		assert property (reply_head_s |=> d2h_valid && (d2h_data == RSP_SET || d2h_data == RSP_GET))
		else $error("reply command byte wrong");
	set_reply_a:
		assert property (reply_head_s ##1 d2h_data == RSP_SET |=> set_tail_s)
		else $error("write answer malformed");
	get_len_a:
		assert property (reply_head_s ##1 d2h_data == RSP_GET |=> d2h_data >= 8'h03 && d2h_data <= 8'h06)
		else $error("read answer length out of range");
	busy_reply_a:
		assert property (d2h_valid |-> rts_n)
		else $error("flow control low during reply");
	ready_after_a:
		assert property ($fell(d2h_valid) && reset_pin_n |-> !rts_n)
		else $error("flow control not low after reply");
	reply_sum_a:
		assert property ($fell(d2h_valid) |-> sum_r == 8'h00)
		else $error("reply checksum wrong");
	host_gap_a:
		assert property (h2d_valid |-> !rts_n ##1 !h2d_valid [*3])
		else $error("host byte while busy or too close");
	// a frame start seen from the host
	host_start_c: cover property (h2d_valid && h2d_data == FRM_START);
endmodule

// ---- verif/host_serial_setup_and_ready_bench.sv ----
module host_serial_setup_and_ready_bench
	import hssr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// one table row: command word, status mask, expected status
	typedef struct packed {
		logic [31:0] cmd;
		logic [31:0] mask;
		logic [31:0] want;
	} hssr_row_type;
	localparam logic [31:0] WM = 32'h00FF_0007; // write ok: status byte, flags
	localparam logic [31:0] EM = 32'h00FF_0003; // write refused: status byte
	localparam logic [31:0] RM = 32'h00FF_FF03; // read: position, value
	localparam logic [31:0] WOK = 32'h0000_0006;
	localparam logic [31:0] WER = 32'h0001_0002;
	localparam hssr_row_type ROWS[18] = '{
		'{32'h0001_0055, RM, 32'h0055_0002},
		'{32'h0001_0056, RM, 32'h0056_0102},
		'{32'h0001_005C, RM, 32'h005C_0002},
		'{32'h0000_0754, WM, WOK},
		'{32'h0000_0954, EM, WER},
		'{32'h0001_0054, RM, 32'h0054_0702},
		'{32'h0000_0055, WM, WOK},
		'{32'h0000_0155, WM, WOK},
		'{32'h0000_0355, EM, WER},
		'{32'h0000_0255, WM, WOK},
		'{32'h0001_0055, RM, 32'h0055_0202},
		'{32'h0000_0256, WM, WOK},
		'{32'h0000_0056, EM, WER},
		'{32'h0001_0056, RM, 32'h0056_0202},
		'{32'h0000_015C, EM, WER},
		'{32'h0000_005C, WM, WOK},
		'{32'h0001_005C, RM, 32'h005C_0002},
		'{32'h0001_0054, RM, 32'h0054_0702}
	};
	// bytes expected on the link for a write of 0x54=08 then its read
	localparam logic [7:0] H_EXP[13] = '{8'h02, 8'h09, 8'h03, 8'h54, 8'h01, 8'h08, 8'h55,
		8'h02, 8'h0A, 8'h02, 8'h54, 8'h01, 8'h5F};
	localparam logic [7:0] D_EXP[12] = '{8'h02, 8'h49, 8'h01, 8'h00, 8'h4A,
		8'h02, 8'h4A, 8'h03, 8'h54, 8'h01, 8'h08, 8'h16};
	// clock, reset, design inputs, and the cfg and rdata design outputs
	logic aclk, aresetn, internal_fault;
	logic [7:0] awaddr, araddr, cfg_word_len, cfg_parity, cfg_stop_bits, cfg_profile;
	logic [31:0] wdata, rdata, cfg_baud;
	logic [3:0] wstrb;
	logic awvalid, wvalid, bready, arvalid, rready;
	// design outputs
	logic awready, wready, bvalid, arready, rvalid, low_power;
	logic [1:0] bresp, rresp;
	// bench state
	int miscompares = 0;
	int n_checks = 0;
	logic [7:0] hq[$];
	logic [7:0] dq[$];
	logic [31:0] rd;
	logic [1:0] rs;
	hssr_link_if link();
	hssr_dev #(.CAL_CYC_P(20)) i_hssr_dev (.aclk(aclk), .aresetn(aresetn), .link(link.dev),
		.internal_fault(internal_fault), .cfg_word_len(cfg_word_len), .cfg_parity(cfg_parity),
		.cfg_stop_bits(cfg_stop_bits), .cfg_profile(cfg_profile), .cfg_baud(cfg_baud),
		.low_power(low_power));
	hssr_host #(.RST_HOLD_P(10)) i_hssr_host (.aclk(aclk), .aresetn(aresetn), .link(link.host),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	hssr_checker i_hssr_checker (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(link.reset_pin_n),
		.rts_n(link.rts_n), .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data),
		.d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data));
	// free-running clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// record every byte that crosses the link
	always @(posedge aclk) begin
		if (link.h2d_valid === 1'b1)
			hq.push_back(link.h2d_data);
		if (link.d2h_valid === 1'b1)
			dq.push_back(link.d2h_data);
	end
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
			miscompares++;
		end
	endtask
	// verdict and end of run
	task automatic wrap_up();
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// a bound used up ends the run
	task automatic hang(input int n, input int lim);
		if (n >= lim) begin
			miscompares++;
			wrap_up();
		end
	endtask
	// axi4-lite write, both halves offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 400; n++) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		hang(n, 400);
		r = bresp;
		bready <= 1'b0;
	endtask
	// axi4-lite read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 400; n++) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		hang(n, 400);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// poll status until the masked bits match; rd keeps the last word
	task automatic wait_stat(input logic [31:0] m, input logic [31:0] w);
		int n;
		for (n = 0; n < 3000; n++) begin
			axi_rd(REG_STAT, rd, rs);
			if ((rd & m) === w)
				break;
		end
		hang(n, 3000);
	endtask
	// one command through the host, waits until it is done
	task automatic do_cmd(input logic [31:0] c);
		logic [1:0] r;
		axi_wr(REG_CMD, c, r);
		chk(32'(r), 32'h0);
		wait_stat(32'h1, 32'h0);
	endtask
	// main sequence
	initial begin
		int n, k;
		{aresetn, internal_fault, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({cfg_word_len, cfg_parity, cfg_stop_bits, cfg_profile}, 32'h0800_0100);
		chk(cfg_baud, 32'h0000_2580);
		axi_wr(REG_CMD, 32'h0000_0854, rs);
		chk(32'(rs), 32'h2);
		axi_rd(8'h0C, rd, rs);
		chk({rd[29:0], rs}, 32'h2);
		axi_rd(REG_CMD, rd, rs);
		chk(32'(rs), 32'h2);
		wait_stat(32'h3, 32'h2);
		chk(32'(low_power), 32'h1);
		hq.delete();
		dq.delete();
		do_cmd(32'h0000_0854);
		do_cmd(32'h0001_0054);
		foreach (H_EXP[i]) chk(32'(hq[i]), 32'(H_EXP[i]));
		foreach (D_EXP[i]) chk(32'(dq[i]), 32'(D_EXP[i]));
		chk(32'(dq.size()), 32'd12);
		foreach (ROWS[i]) begin
			do_cmd(ROWS[i].cmd);
			chk(rd & ROWS[i].mask, ROWS[i].want);
		end
		chk({cfg_word_len, cfg_parity, cfg_stop_bits, cfg_profile}, 32'h0702_0200);
		// software settles back on eight data bits and one stop bit
		do_cmd(32'h0000_0854);
		chk(rd & WM, WOK);
		do_cmd(32'h0000_0156);
		chk(rd & WM, WOK);
		chk(32'({cfg_word_len, cfg_stop_bits}), 32'({DEF_WORD, DEF_STOP}));
		// asleep device wakes on the first host byte, busy only for the wake time
		for (n = 0; n < 100 && low_power !== 1'b1; n++) @(posedge aclk);
		hang(n, 100);
		axi_wr(REG_CMD, 32'h0001_0054, rs);
		for (n = 0; n < 100 && link.rts_n !== 1'b1; n++) @(posedge aclk);
		hang(n, 100);
		for (k = 0; k < 100 && link.rts_n === 1'b1; k++) @(posedge aclk);
		hang(k, 100);
		chk(32'(rs), 32'h0);
		chk(32'(k), 32'(WAKE_CYC));
		wait_stat(32'h1, 32'h0);
		chk(rd & RM, 32'h0054_0802);
		// restart through the reset pin
		axi_wr(REG_RST, 32'h0, rs);
		chk(32'(rs), 32'h0);
		for (n = 0; n < 50 && link.reset_pin_n !== 1'b0; n++) @(posedge aclk);
		hang(n, 50);
		for (k = 0; k < 50 && link.reset_pin_n === 1'b0; k++) @(posedge aclk);
		hang(k, 50);
		chk(32'(k >= 10), 32'h1);
		chk(32'(link.rts_n), 32'h1);
		wait_stat(32'h3, 32'h2);
		do_cmd(32'h0001_0055);
		chk(rd & RM, 32'h0055_0202);
		// serious internal error restarts the device
		@(posedge aclk);
		internal_fault <= 1'b1;
		@(posedge aclk);
		internal_fault <= 1'b0;
		@(posedge aclk);
		chk(32'(link.rts_n), 32'h1);
		for (n = 0; n < 3000 && link.rts_n !== 1'b0; n++) @(posedge aclk);
		hang(n, 3000);
		do_cmd(32'h0001_0054);
		chk(rd & RM, 32'h0054_0802);
		wrap_up();
	end
endmodule
